// file: i2cm_master.sv
// Decided for this implementation: strobed register access and the placing of the registers.
`default_nettype none
module i2cm_master
  import i2cm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire i2cm_req_t reg_req,
  output var logic [7:0] reg_rdata,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output var i2cm_pins_t pins,
  // Status
  output var logic busy
);
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

  typedef struct packed {
    i2cm_st_t master_state_reg;
    logic [1:0] master_substate_reg;
    logic [7:0] tick_cnt;
    logic scl_meta;
    logic scl_s;
    logic sda_meta;
    logic sda_s;
    i2cm_pins_t port_direction_shadow;
    logic [3:0] bits_left_counter;
    logic [7:0] shift_byte;
    logic [3:0] write_index;
    logic [3:0] read_index;
    logic [7:0] transfer_length;
    logic [6:0] target_address;
    logic rd_mode;
    logic mm_en;
    logic addr_phase;
    logic samp;
    logic no_ack_flag;
    logic receive_done_flag;
    logic arbitration_lost_flag;
    logic resume_is_write_flag;
    logic bus_owned_flag;
    logic [7:0] start_delay_counter;
    logic [8:0] backoff;
    logic [7:0] lfsr;
    logic [BUF_DEPTH-1:0][7:0] data_buffer;
    logic [7:0] rdata;
  } i2cm_state_t;

  i2cm_state_t s_q;
  i2cm_state_t s_d;
  logic tick;
  logic more;
  logic drv_low;
  logic lose;
  logic [6:0] wait_clks;

  function automatic logic is_buf(input logic [3:0] a);
    is_buf = (a >= OFS_BUF) && (a < OFS_BUF + 4'(BUF_DEPTH));
  endfunction

  assign tick = ce && (s_q.tick_cnt == 8'h00);
  assign more = {4'h0, s_q.read_index} < s_q.transfer_length;
  assign wait_clks = (s_q.lfsr[6:0] >= 7'(BACKOFF_MAX_CLKS))
                   ? 7'(s_q.lfsr[6:0] - 7'(BACKOFF_MAX_CLKS)) : s_q.lfsr[6:0];

  always_comb
  begin
    s_d = s_q;
    drv_low = 1'b0;
    lose = 1'b0;
    if (ce)
    begin
      s_d.scl_meta = scl_i;
      s_d.scl_s = s_q.scl_meta;
      s_d.sda_meta = sda_i;
      s_d.sda_s = s_q.sda_meta;
      s_d.lfsr = {s_q.lfsr[6:0], s_q.lfsr[7] ^ s_q.lfsr[5] ^ s_q.lfsr[4] ^ s_q.lfsr[3]};
      s_d.tick_cnt = (s_q.tick_cnt == 8'h00) ? TICK_LAST : 8'(s_q.tick_cnt - 8'h01);

      // Register reads, answered one cycle later
      if (reg_req.rd)
      begin
        s_d.rdata = 8'h00;
        if (reg_req.addr == OFS_CTRL)
          s_d.rdata = {5'h00, s_q.mm_en, s_q.rd_mode, 1'b0};
        else if (reg_req.addr == OFS_STAT)
          s_d.rdata = {2'h0, s_q.master_state_reg != ST_IDLE, s_q.bus_owned_flag,
                       s_q.resume_is_write_flag, s_q.arbitration_lost_flag,
                       s_q.receive_done_flag, s_q.no_ack_flag};
        else if (reg_req.addr == OFS_ADDR)
          s_d.rdata = {1'b0, s_q.target_address};
        else if (reg_req.addr == OFS_LEN)
          s_d.rdata = s_q.transfer_length;
        else if (reg_req.addr == OFS_STATE)
          s_d.rdata = {s_q.master_substate_reg, 2'h0, s_q.master_state_reg};
        else if (is_buf(reg_req.addr))
          s_d.rdata = s_q.data_buffer[3'(reg_req.addr - OFS_BUF)];
      end

      // Writes; flag clears come first so a same-cycle set wins
      if (reg_req.wr)
      begin
        if (reg_req.addr == OFS_STAT)
        begin
          if (reg_req.wdata[STAT_NO_ACK])
            s_d.no_ack_flag = 1'b0;
          if (reg_req.wdata[STAT_RX_DONE])
            s_d.receive_done_flag = 1'b0;
          if (reg_req.wdata[STAT_ARB_LOST])
            s_d.arbitration_lost_flag = 1'b0;
        end
        // Configuration only changes while idle, so a transfer sees stable values
        if (s_q.master_state_reg == ST_IDLE)
        begin
          // target address held for the transfer
          if (reg_req.addr == OFS_ADDR)
            s_d.target_address = reg_req.wdata[6:0];
          if (reg_req.addr == OFS_LEN)
            s_d.transfer_length = reg_req.wdata;
          if (is_buf(reg_req.addr))
            s_d.data_buffer[3'(reg_req.addr - OFS_BUF)] = reg_req.wdata;
          if (reg_req.addr == OFS_CTRL)
          begin
            s_d.rd_mode = reg_req.wdata[CTRL_READ];
            s_d.mm_en = reg_req.wdata[CTRL_MM];
            if (reg_req.wdata[CTRL_GO])
            begin
              s_d.master_state_reg = ST_START;
              s_d.master_substate_reg = 2'd0;
              s_d.start_delay_counter = 8'h00;
            end
          end
        end
      end

      if (tick)
      begin
        unique case (s_q.master_state_reg)
          ST_IDLE:
          begin
            s_d.port_direction_shadow.scl_oe = 1'b0;
            s_d.port_direction_shadow.sda_oe = 1'b0;
          end
          ST_START:
          begin
            unique case (s_q.master_substate_reg)
              2'd0:
              begin
                s_d.port_direction_shadow.scl_oe = 1'b0;
                s_d.port_direction_shadow.sda_oe = 1'b0;
                // count clock-high periods on a free bus
                if (!s_q.mm_en)
                  s_d.master_substate_reg = 2'd1;
                else if (s_q.scl_s && s_q.sda_s)
                begin
                  s_d.start_delay_counter = 8'(s_q.start_delay_counter + 8'h01);
                  if (s_q.start_delay_counter >= 8'(START_DELAY_TICKS - 1))
                    s_d.master_substate_reg = 2'd1;
                end
                else
                  s_d.start_delay_counter = 8'h00;
              end
              2'd1:
              begin
                s_d.port_direction_shadow.sda_oe = 1'b1;
                // this master now owns the bus
                s_d.bus_owned_flag = 1'b1;
                s_d.master_substate_reg = 2'd2;
              end
              2'd2:
              begin
                s_d.port_direction_shadow.scl_oe = 1'b1;
                s_d.master_substate_reg = 2'd3;
              end
              default:
              begin
                s_d.master_state_reg = ST_PREP_ADDR;
                s_d.master_substate_reg = 2'd0;
              end
            endcase
          end
          ST_PREP_ADDR:
          begin
            // address into the shift byte; direction bit
            s_d.shift_byte = {s_q.target_address, s_q.rd_mode};
            s_d.bits_left_counter = 4'd8;
            s_d.addr_phase = 1'b1;
            s_d.write_index = 4'h0;
            s_d.read_index = 4'h0;
            s_d.master_state_reg = ST_SHIFT_OUT;
          end
          ST_PREP_SEND:
          begin
            // count, fetch and advance; write index
            s_d.shift_byte = s_q.data_buffer[3'(s_q.write_index)];
            s_d.write_index = 4'(s_q.write_index + 4'h1);
            s_d.bits_left_counter = 4'd8;
            s_d.master_state_reg = ST_SHIFT_OUT;
          end
          ST_MORE_SEND:
          begin
            if (({4'h0, s_q.write_index} < s_q.transfer_length)
                && (s_q.write_index < 4'(BUF_DEPTH)))
              s_d.master_state_reg = ST_PREP_SEND;
            else
              s_d.master_state_reg = ST_STOP;
          end
          ST_PREP_RX:
          begin
            s_d.bits_left_counter = 4'd8;
            s_d.master_state_reg = ST_SHIFT_IN;
          end
          ST_STORE:
          begin
            // byte to the next buffer slot
            s_d.data_buffer[3'(s_q.read_index)] = s_q.shift_byte;
            s_d.read_index = 4'(s_q.read_index + 4'h1);
            s_d.master_state_reg = ST_DRIVE_ACK;
          end
          ST_STOP:
          begin
            // data rises while clock high, then idle
            unique case (s_q.master_substate_reg)
              2'd0: s_d.port_direction_shadow.sda_oe = 1'b1;
              2'd1: s_d.port_direction_shadow.scl_oe = 1'b0;
              2'd2: s_d.port_direction_shadow.sda_oe = !s_q.scl_s;
              default:
              begin
                s_d.master_state_reg = ST_IDLE;
                s_d.bus_owned_flag = 1'b0;
              end
            endcase
            // Slave may still stretch; data must rise with clock high
            if ((s_q.master_substate_reg != 2'd2) || s_q.scl_s)
              s_d.master_substate_reg = 2'(s_q.master_substate_reg + 2'd1);
          end
          ST_BACKOFF:
          begin
            // random wait, then retry the whole transfer
            if (s_q.backoff == 9'h000)
            begin
              s_d.master_state_reg = ST_START;
              s_d.start_delay_counter = 8'h00;
            end
            else
              s_d.backoff = 9'(s_q.backoff - 9'h001);
          end
          ST_SHIFT_OUT, ST_SAMPLE_ACK, ST_SHIFT_IN, ST_DRIVE_ACK:
          begin
            if (s_q.master_state_reg == ST_SHIFT_OUT)
              drv_low = !s_q.shift_byte[7];
            else if (s_q.master_state_reg == ST_DRIVE_ACK)
              drv_low = more;
            unique case (s_q.master_substate_reg)
              2'd0:
              begin
                // data changes while the clock is low
                s_d.port_direction_shadow.sda_oe = drv_low;
                s_d.master_substate_reg = 2'd1;
              end
              2'd1:
              begin
                s_d.port_direction_shadow.scl_oe = 1'b0;
                s_d.master_substate_reg = 2'd2;
              end
              2'd2:
              begin
                // Waits while a slave stretches the clock
                if (s_q.scl_s)
                begin
                  s_d.samp = s_q.sda_s;
                  s_d.master_substate_reg = 2'd3;
                  lose = s_q.mm_en && (s_q.master_state_reg == ST_SHIFT_OUT)
                      && !s_q.port_direction_shadow.sda_oe && !s_q.sda_s;
                end
              end
              default:
              begin
                s_d.port_direction_shadow.scl_oe = 1'b1;
                s_d.master_substate_reg = 2'd0;
                if (s_q.master_state_reg == ST_SHIFT_OUT)
                begin
                  s_d.shift_byte = {s_q.shift_byte[6:0], 1'b0};
                  s_d.bits_left_counter = 4'(s_q.bits_left_counter - 4'd1);
                  if (s_q.bits_left_counter == 4'd1)
                    s_d.master_state_reg = ST_SAMPLE_ACK;
                end
                else if (s_q.master_state_reg == ST_SHIFT_IN)
                begin
                  s_d.shift_byte = {s_q.shift_byte[6:0], s_q.samp};
                  s_d.bits_left_counter = 4'(s_q.bits_left_counter - 4'd1);
                  if (s_q.bits_left_counter == 4'd1)
                    s_d.master_state_reg = ST_STORE;
                end
                else if (s_q.master_state_reg == ST_SAMPLE_ACK)
                begin
                  s_d.addr_phase = 1'b0;
                  if (s_q.samp)
                  begin
                    s_d.no_ack_flag = 1'b1;
                    s_d.master_state_reg = ST_STOP;
                  end
                  else if (s_q.addr_phase && s_q.rd_mode)
                    s_d.master_state_reg = ST_PREP_RX;
                  else
                    s_d.master_state_reg = ST_MORE_SEND;
                end
                else if (more)
                  s_d.master_state_reg = ST_PREP_RX;
                else
                begin
                  s_d.receive_done_flag = 1'b1;
                  s_d.master_state_reg = ST_STOP;
                end
              end
            endcase
          end
          default:
            s_d.master_state_reg = ST_IDLE;
        endcase

        if (lose)
        begin
          // flag the loss; remember the direction
          s_d.arbitration_lost_flag = 1'b1;
          s_d.resume_is_write_flag = !s_q.rd_mode;
          s_d.bus_owned_flag = 1'b0;
          s_d.port_direction_shadow.scl_oe = 1'b0;
          s_d.port_direction_shadow.sda_oe = 1'b0;
          s_d.backoff = {7'(wait_clks + 7'd1), 2'b00};
          s_d.master_state_reg = ST_BACKOFF;
          s_d.master_substate_reg = 2'd0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.scl_meta <= 1'b1;
      s_q.scl_s <= 1'b1;
      s_q.sda_meta <= 1'b1;
      s_q.sda_s <= 1'b1;
      s_q.lfsr <= LFSR_SEED;
    end
    else
      s_q <= s_d;
  end

  assign reg_rdata = s_q.rdata;
  assign pins = s_q.port_direction_shadow;
  assign busy = s_q.bus_owned_flag;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n || !ce);

  sequence seq_ack_nack;
    s_q.master_state_reg == ST_SAMPLE_ACK && tick && s_q.master_substate_reg == 2'd3
      && s_q.samp;
  endsequence
  sequence seq_rx_last;
    s_q.master_state_reg == ST_DRIVE_ACK && tick && s_q.master_substate_reg == 2'd3 && !more;
  endsequence

  a_idle_released: assert property (s_q.master_state_reg == ST_IDLE && $past(s_q.master_state_reg) == ST_IDLE |-> !pins.scl_oe && !pins.sda_oe) else $error("line driven in idle");
  a_start_order: assert property ($rose(pins.sda_oe) && !pins.scl_oe |-> $past(s_q.master_state_reg) == ST_START) else $error("data fell with clock high outside start");
  a_prep_fetch: assert property (s_q.master_state_reg == ST_PREP_SEND && tick |=> s_q.bits_left_counter == 4'd8 && s_q.write_index == 4'($past(s_q.write_index) + 4'h1)) else $error("byte preparation wrong");
  a_nack_stop: assert property (seq_ack_nack |=> s_q.no_ack_flag && s_q.master_state_reg == ST_STOP) else $error("missing ack not handled");
  a_stop_order: assert property ($fell(pins.sda_oe) && !pins.scl_oe && !$fell(pins.scl_oe) && $past(s_q.master_state_reg) != ST_BACKOFF |-> $past(s_q.master_state_reg) == ST_STOP || $past(s_q.master_state_reg) == ST_IDLE) else $error("data rose with clock high outside stop");
  a_rx_eight: assert property (s_q.master_state_reg == ST_STORE && $past(s_q.master_state_reg) == ST_SHIFT_IN |-> s_q.bits_left_counter == 4'd0) else $error("received byte not eight bits");
  a_store_slot: assert property (s_q.master_state_reg == ST_STORE && tick |=> s_q.data_buffer[3'($past(s_q.read_index))] == $past(s_q.shift_byte)) else $error("byte not stored");
  a_ack_choice: assert property (s_q.master_state_reg == ST_DRIVE_ACK && s_q.master_substate_reg != 2'd0 |-> pins.sda_oe == more) else $error("wrong ack level");
  a_rx_done: assert property (seq_rx_last |=> s_q.receive_done_flag ##0 s_q.master_state_reg == ST_STOP) else $error("receive done not set");
  a_arb_lost: assert property (lose && tick |=> s_q.arbitration_lost_flag && !s_q.bus_owned_flag && s_q.master_state_reg == ST_BACKOFF) else $error("arbitration loss not taken");
  a_bus_owned: assert property (s_q.master_state_reg == ST_SHIFT_OUT |-> s_q.bus_owned_flag) else $error("shifting without ownership");
  a_tick_space: assert property (tick |=> !tick [*8]) else $error("tick too fast");
endmodule
`default_nettype wire

// file: i2cm_pkg.sv
`default_nettype none
package i2cm_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int BUS_HZ = 100_000;
  localparam int TICKS_PER_BIT = 4;
  localparam int TICK_CYC = CLK_HZ / (BUS_HZ * TICKS_PER_BIT);
  localparam int START_DELAY_TICKS = 8;
  localparam int BACKOFF_MAX_CLKS = 85;
  localparam int BUF_DEPTH = 7;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h1;
  localparam logic [3:0] OFS_ADDR = 4'h2;
  localparam logic [3:0] OFS_LEN = 4'h3;
  localparam logic [3:0] OFS_STATE = 4'h4;
  localparam logic [3:0] OFS_BUF = 4'h8;
  localparam int CTRL_GO = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_MM = 2;
  localparam int STAT_NO_ACK = 0;
  localparam int STAT_RX_DONE = 1;
  localparam int STAT_ARB_LOST = 2;
  localparam int STAT_RESUME_WR = 3;
  localparam int STAT_OWNED = 4;
  localparam int STAT_BUSY = 5;
  localparam logic [7:0] LFSR_SEED = 8'h5a;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_START = 4'h1, ST_PREP_ADDR = 4'h3, ST_SHIFT_OUT = 4'h2,
    ST_SAMPLE_ACK = 4'h6, ST_MORE_SEND = 4'h7, ST_PREP_SEND = 4'h5, ST_STOP = 4'h4,
    ST_PREP_RX = 4'hc, ST_SHIFT_IN = 4'hd, ST_STORE = 4'hf, ST_DRIVE_ACK = 4'he,
    ST_BACKOFF = 4'ha
  } i2cm_st_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } i2cm_req_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } i2cm_pins_t;
endpackage
`default_nettype wire

// file: i2cm_slave_model.sv
`default_nettype none
module i2cm_slave_model
#(
  parameter logic [6:0] DEV_ADDR = 7'h50
)
(
  // Bus lines
  input wire logic scl,
  input wire logic sda,
  output var logic scl_oe,
  output var logic sda_oe,
  // Slow answer, zero for prompt
  input wire logic [31:0] stretch_ns
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [8];
  logic [7:0] sh, tx, abyte;
  logic active = 1'b0;
  logic addr_ph, rd, first, sending, m_ack;
  int bitn, ptr, sent;
  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // Start: the falling clock right after it is not a bit
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      active = 1'b1;
      addr_ph = 1'b1;
      rd = 1'b0;
      sending = 1'b0;
      bitn = -1;
      ptr = 0;
      sent = 0;
    end
  always @(posedge sda)
    if (scl === 1'b1)
      active = 1'b0;
  always @(posedge scl)
    if (active)
    begin
      if (bitn < 8)
        sh = {sh[6:0], sda};
      else
        m_ack = !sda;
    end
  always @(negedge scl)
    if (active)
    begin
      bitn++;
      if (bitn == 9)
      begin
        bitn = 0;
        sda_oe = 1'b0;
        sending = rd && (first || m_ack);
        first = 1'b0;
        if (sending)
        begin
          tx = mem[ptr];
          ptr++;
          sent++;
        end
      end
      else if (bitn == 8)
      begin
        if (addr_ph)
        begin
          abyte = sh;
          addr_ph = 1'b0;
          rd = sh[0];
          first = sh[0];
          active = (sh[7:1] == DEV_ADDR);
        end
        else if (!sending)
        begin
          mem[ptr] = sh;
          ptr++;
        end
        // Released while the master gives its own ack
        sda_oe = active && !sending;
      end
      if (sending && bitn < 8)
        sda_oe = !tx[7 - bitn];
    end
  // Holding the clock low tests that the master waits
  always @(negedge scl)
    if (active && stretch_ns != 0)
    begin
      scl_oe = 1'b1;
      #(stretch_ns);
      scl_oe = 1'b0;
    end
endmodule
`default_nettype wire

// file: testbench.sv
`default_nettype none
module testbench
  import i2cm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV = 7'h50;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  i2cm_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  i2cm_pins_t pins;
  logic busy;
  logic s_scl_oe, s_sda_oe;
  logic [31:0] stretch = '0;
  wire logic scl = !(pins.scl_oe || s_scl_oe);
  // Second master pulling data low
  logic rival_sda_oe = 1'b0;
  wire logic sda = !(pins.sda_oe || s_sda_oe || rival_sda_oe);
  int num_errors = 0;
  int n_compared = 0;
  int n_start, n_stop;
  logic [7:0] d;
  logic [7:0] tx [2];
  realtime t0;

  always #5 core_clk = ~core_clk;

  i2cm_master i_dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .scl_i(scl), .sda_i(sda), .pins(pins), .busy(busy));
  i2cm_slave_model #(.DEV_ADDR(DEV)) i_slave (.scl(scl), .sda(sda), .scl_oe(s_scl_oe),
    .sda_oe(s_sda_oe), .stretch_ns(stretch));

  always @(negedge sda) if (scl === 1'b1) n_start++;
  always @(posedge sda) if (scl === 1'b1) n_stop++;

  function automatic logic [7:0] addr_byte(input logic [6:0] a, input logic r);
    return {a, r};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_req <= '{a, v, 1'b1, 1'b0};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    @(posedge core_clk);
    v = reg_rdata;
  endtask

  // Bounded waits: ownership must begin, then end
  task automatic wait_idle();
    int i;
    i = 0;
    while (busy !== 1'b1 && i < 4000)
    begin
      @(posedge core_clk);
      i++;
    end
    chk({7'h0, busy}, 8'h01);
    i = 0;
    while (busy !== 1'b0 && i < 50000)
    begin
      @(posedge core_clk);
      i++;
    end
    chk({7'h0, busy}, 8'h00);
  endtask

  task automatic run_write();
    for (int k = 0; k < 2; k++)
    begin
      tx[k] = 8'($urandom);
      wr(OFS_BUF + 4'(k), tx[k]);
    end
    wr(OFS_ADDR, {1'b0, DEV});
    wr(OFS_LEN, 8'h02);
    wr(OFS_CTRL, 8'h01);
    @(posedge scl);
    t0 = $realtime;
    @(posedge scl);
    chk(8'(($realtime - t0) > 9.9e3 && ($realtime - t0) < 10.1e3), 8'h01);
    wait_idle();
    chk(i_slave.abyte, addr_byte(DEV, 1'b0));
    chk(i_slave.mem[0], tx[0]);
    chk(i_slave.mem[1], tx[1]);
    rd(OFS_STAT, d);
    chk(d & 8'h07, 8'h00);
    $display("write test done at %0t", $time);
  endtask

  task automatic run_read();
    int n;
    n = 1 + $urandom % 2;
    stretch = 32'd8000;
    for (int k = 0; k < 2; k++)
    begin
      tx[k] = 8'($urandom);
      i_slave.mem[k] = tx[k];
    end
    wr(OFS_LEN, 8'(n));
    wr(OFS_CTRL, 8'h03);
    rd(OFS_CTRL, d);
    chk(d, 8'h02);
    n_start = 0;
    n_stop = 0;
    wait_idle();
    chk(i_slave.abyte, addr_byte(DEV, 1'b1));
    chk(8'(i_slave.sent), 8'(n));
    for (int k = 0; k < n; k++)
    begin
      rd(OFS_BUF + 4'(k), d);
      chk(d, tx[k]);
    end
    rd(OFS_STAT, d);
    chk(d & 8'h07, 8'h02);
    wr(OFS_STAT, 8'h07);
    rd(OFS_STAT, d);
    chk(d & 8'h07, 8'h00);
    stretch = '0;
    $display("read test done at %0t", $time);
  endtask

  task automatic run_nack();
    wr(OFS_ADDR, {1'b0, DEV ^ 7'h01});
    wr(OFS_LEN, 8'h01);
    n_start = 0;
    n_stop = 0;
    wr(OFS_CTRL, 8'h01);
    wait_idle();
    chk(8'(n_start), 8'h01);
    chk(8'(n_stop), 8'h01);
    rd(OFS_STAT, d);
    chk(d & 8'h07, 8'h01);
    chk({4'h0, pins.scl_oe, pins.sda_oe, scl, sda}, 8'h03);
    rd(4'h7, d);
    chk(d, 8'h00);
    $display("nack test done at %0t", $time);
  endtask

  // Rival holds data low after start; loss is checked, then reset cuts the backoff
  task automatic run_arb();
    int i;
    i = 0;
    n_start = 0;
    wr(OFS_ADDR, {1'b0, DEV});
    wr(OFS_CTRL, 8'h05);
    while (n_start == 0 && i < 4000)
    begin
      @(posedge core_clk);
      i++;
    end
    chk(8'(i >= START_DELAY_TICKS * TICK_CYC), 8'h01);
    rival_sda_oe <= 1'b1;
    wait_idle();
    rd(OFS_STAT, d);
    chk(d & 8'h3c, 8'h2c);
    rd(OFS_STATE, d);
    chk(d, 8'(ST_BACKOFF));
    chk({6'h0, pins.scl_oe, pins.sda_oe}, 8'h00);
    rival_sda_oe <= 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(OFS_STAT, d);
    chk(d, 8'h00);
    chk({4'h0, pins.scl_oe, pins.sda_oe, scl, sda}, 8'h03);
    $display("arbitration test done at %0t", $time);
  endtask

  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #1_000_000;
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(90));
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk({4'h0, pins.scl_oe, pins.sda_oe, scl, sda}, 8'h03);
    rd(OFS_STAT, d);
    chk(d, 8'h00);
    n_start = 0;
    n_stop = 0;
    run_write();
    run_read();
    run_nack();
    run_arb();
    report_and_stop();
  end
endmodule
`default_nettype wire
